// ---- core/ciaf_accept_flags.sv ----
// interrupt accept flags: enable, stack select and priority level
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

// How it works
// - enable flag 0 blocks maskable requests
// - an acknowledge taken while a request is offered clears the enable flag
// - stack select 0 interrupt, 1 user
// - acknowledge or low software interrupt clears select
// - priority level is three bits, 0 to 7
// - request needs level strictly above processor level
// - reserved flag bit written 0, read undefined
// - control registers reset low three bits only
module ciaf_accept_flags #(
    parameter int NUM_SRC = 8
) (
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    input  wire ciaf_pkg::ciaf_bus_t             bus,
    output      logic [ciaf_pkg::DW-1:0]         rdata,
    input  wire logic [NUM_SRC-1:0]              src_req,
    input  wire logic                            ack,
    input  wire logic                            swi_exec,
    input  wire logic [ciaf_pkg::SWI_W-1:0]      swi_num,
    input  wire logic                            flags_load,
    input  wire ciaf_pkg::ciaf_flags_t           flags_val,
    output      ciaf_pkg::ciaf_irq_t             irq,
    output      ciaf_pkg::ciaf_flags_t           flags,
    output      logic                            user_sp
);
    import ciaf_pkg::*;

    if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_bad_num
        $error("NUM_SRC must lie in 1..16");
    end

    // the flag byte and the split pending read assume 8-bit registers
    if ($bits(ciaf_flags_t) != DW || MAX_SRC != 2 * DW) begin : g_bad_pkg
        $error("package widths do not fit the register layout");
    end

    function automatic logic src_hit(input logic [AW-1:0] a, input int i);
        return a == (OFF_SRC + AW'(i));
    endfunction

    ciaf_flags_t            flags_reg;
    ciaf_flags_t            flags_next;
    ciaf_irq_t              irq_reg;
    ciaf_irq_t              irq_next;
    logic [DW-1:0]          last_reg;
    logic [DW-1:0]          last_next;
    logic [DW-1:0]          rdata_reg;
    logic [DW-1:0]          rdata_next;

    ciaf_irq_t              win;
    logic                   ack_take;
    logic                   flags_wr;
    logic [DW-1:0]          ctrl     [NUM_SRC];
    logic [NUM_SRC-1:0]     ctrl_wr;
    logic [NUM_SRC-1:0]     ack_clr;
    logic [NUM_SRC-1:0]     pend;
    ciaf_lvl_t [NUM_SRC-1:0] lvl;
    logic [MAX_SRC-1:0]     pend_all;
    ciaf_flags_t            rd_flags;

    // an acknowledge only counts while a request is on offer
    assign ack_take = ack && irq_reg.valid;
    assign flags_wr = bus.wr && (bus.addr == OFF_FLAGS);

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign ctrl_wr[i] = bus.wr && src_hit(bus.addr, i);
        assign ack_clr[i] = ack_take && (irq_reg.num == VEC_W'(i));
        assign pend[i]    = ctrl[i][CTRL_REQ_BIT];
        assign lvl[i]     = ctrl[i][LVL_W-1:0];

        ciaf_src_ctrl u_src (
            .mclk    (mclk),
            .rstn    (rstn),
            .wr_en   (ctrl_wr[i]),
            .wdata   (bus.wdata),
            .req_in  (src_req[i]),
            .ack_clr (ack_clr[i]),
            .ctrl    (ctrl[i])
        );
    end

    for (genvar i = 0; i < MAX_SRC; i++) begin : g_pend
        if (i < NUM_SRC) begin : g_used
            assign pend_all[i] = pend[i];
        end else begin : g_unused
            assign pend_all[i] = 1'b0;
        end
    end

    ciaf_arbiter #(
        .NUM_SRC (NUM_SRC)
    ) u_arb (
        .gie  (flags_reg.gie),
        .ppl  (flags_reg.ppl),
        .pend (pend),
        .lvl  (lvl),
        .win  (win)
    );

    // flag byte: later assignments take priority
    always_comb begin
        flags_next = flags_reg;
        if (flags_wr) begin
            flags_next           = ciaf_flags_t'(bus.wdata);
            flags_next.rsv       = 1'b0;
            flags_next.pad3      = 1'b0;
            flags_next.pad7      = 1'b0;
        end
        // the core restores saved flags on return from a handler
        if (flags_load) begin
            flags_next           = flags_val;
            flags_next.rsv       = 1'b0;
            flags_next.pad3      = 1'b0;
            flags_next.pad7      = 1'b0;
        end
        if (swi_exec) begin
            flags_next.gie = 1'b0;
            if (swi_num <= SWI_SP_MAX) begin
                flags_next.stack_sel = 1'b0;
            end
        end
        // hardware acknowledge wins over every other source of change
        if (ack_take) begin
            flags_next.gie       = 1'b0;
            flags_next.stack_sel = 1'b0;
            flags_next.ppl       = irq_reg.level;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            flags_reg <= ciaf_flags_t'(FLAGS_RST);
        end else begin
            flags_reg <= flags_next;
        end
    end

    // offer to the core; dropped at once after a take so it is not taken twice
    always_comb begin
        irq_next = win;
        if (ack_take) begin
            irq_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // last accepted vector; seen bit clears on read, a new take wins
    always_comb begin
        last_next = last_reg;
        if (bus.rd && (bus.addr == OFF_LAST)) begin
            last_next[LAST_SEEN_BIT] = 1'b0;
        end
        if (ack_take) begin
            last_next                = '0;
            last_next[VEC_W-1:0]     = irq_reg.num;
            last_next[LAST_SEEN_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            last_reg <= LAST_RST;
        end else begin
            last_reg <= last_next;
        end
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_comb begin
        rdata_next = '0;
        if (bus.rd) begin
            case (bus.addr)
                OFF_FLAGS: begin
                    rdata_next = DW'(flags_reg);
                end
                OFF_PEND_LO: begin
                    rdata_next = pend_all[DW-1:0];
                end
                OFF_PEND_HI: begin
                    rdata_next = pend_all[MAX_SRC-1:DW];
                end
                OFF_LAST: begin
                    rdata_next = last_reg;
                end
                default: begin
                    for (int i = 0; i < NUM_SRC; i++) begin
                        if (src_hit(bus.addr, i)) begin
                            rdata_next = ctrl[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata   = rdata_reg;
    assign irq     = irq_reg;
    assign flags   = flags_reg;
    // 0 selects the interrupt stack pointer, 1 the user stack pointer
    assign user_sp = flags_reg.stack_sel;
    assign rd_flags = ciaf_flags_t'(rdata);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_off_blocks_req: assert property (
        !flags_reg.gie |=> !irq_reg.valid
    ) else $error("request offered while enable flag was 0");

    a_ack_clears_gie: assert property (
        ack_take |=> !flags_reg.gie && !irq_reg.valid
    ) else $error("enable flag survived an acknowledge");

    a_sp_set_cause: assert property (
        $rose(flags_reg.stack_sel) |-> $past(flags_wr || flags_load) && user_sp
    ) else $error("stack select rose without a write or load");

    a_ack_clears_sp: assert property (
        ack_take |=> !flags_reg.stack_sel && !user_sp
    ) else $error("stack select survived an acknowledge");

    a_swi_low_sp: assert property (
        swi_exec && (swi_num <= SWI_SP_MAX) |=> !flags_reg.stack_sel && !flags_reg.gie
    ) else $error("low software interrupt left flags set");

    a_ppl_takes_lvl: assert property (
        ack_take |=> flags_reg.ppl == $past(irq_reg.level)
    ) else $error("priority level not raised to accepted level");

    a_prio_above_ppl: assert property (
        irq_reg.valid |-> irq_reg.level > $past(flags_reg.ppl)
    ) else $error("request offered at or below processor level");

    a_rsv_reads_zero: assert property (
        bus.rd && (bus.addr == OFF_FLAGS) |=> rd_flags.rsv == 1'b0
    ) else $error("reserved flag bit read back as 1");

    a_accept_needs_gie: assert property (
        irq_reg.valid |-> $past(flags_reg.gie) && (|($past(pend_all) & (MAX_SRC'(1) << irq_reg.num)))
    ) else $error("request offered without enable or pending source");

    a_rdata_one_cycle: assert property (
        !$past(bus.rd) |-> rdata == '0
    ) else $error("read data outside the answer cycle");

    // the next two checks look at software interrupts alone, so ack, write and load are kept out
    a_swi_keeps_ppl: assert property (
        swi_exec && !ack_take && !flags_wr && !flags_load |=> flags_reg.ppl == $past(flags_reg.ppl)
    ) else $error("software interrupt changed the priority level");

    a_high_swi_keeps_sp: assert property (
        swi_exec && (swi_num > SWI_SP_MAX) && !ack_take && !flags_wr && !flags_load
            |=> flags_reg.stack_sel == $past(flags_reg.stack_sel)
    ) else $error("high software interrupt changed stack select");

    // swi and ack outrank a load in the same cycle
    a_load_restores: assert property (
        flags_load && !swi_exec && !ack_take |=> flags_reg.ppl == $past(flags_val.ppl)
            && flags_reg.stack_sel == $past(flags_val.stack_sel)
            && flags_reg.gie == $past(flags_val.gie)
    ) else $error("flag restore did not land");

    a_pad_bits_zero: assert property (
        !flags_reg.rsv && !flags_reg.pad3 && !flags_reg.pad7
    ) else $error("reserved or pad flag bit set");

    a_win_above_ppl: assert property (
        win.valid |-> flags_reg.gie && pend_all[win.num] && (win.level > flags_reg.ppl)
    ) else $error("arbiter picked a source at or below processor level");

    a_last_records: assert property (
        ack_take |=> last_reg[LAST_SEEN_BIT] && (last_reg[VEC_W-1:0] == $past(irq_reg.num))
    ) else $error("last vector not recorded on acknowledge");

    // a fresh request in the ack cycle wins, so it is left out
    a_ack_drops_req: assert property (
        ack_take && !(|src_req) |=> !pend_all[$past(irq_reg.num)]
    ) else $error("accepted request still pending");

    c_ack_taken: cover property (ack_take);
    c_swi_low: cover property (swi_exec && (swi_num <= SWI_SP_MAX));
    c_held_off: cover property (flags_reg.gie && (|pend) && !win.valid);
    c_load_restore: cover property (flags_load && flags_val.gie);
endmodule

// ---- core/ciaf_pkg.sv ----
// constants and types shared by the interrupt accept flag unit
package ciaf_pkg;
    localparam int AW       = 8;
    localparam int DW       = 8;
    localparam int MAX_SRC  = 16;
    localparam int VEC_W    = 4;
    localparam int LVL_W    = 3;
    localparam int SWI_W    = 6;

    localparam logic [AW-1:0] OFF_FLAGS   = 8'h00;
    localparam logic [AW-1:0] OFF_PEND_LO = 8'h01;
    localparam logic [AW-1:0] OFF_PEND_HI = 8'h02;
    localparam logic [AW-1:0] OFF_LAST    = 8'h03;
    localparam logic [AW-1:0] OFF_SRC     = 8'h10;

    localparam int CTRL_REQ_BIT  = 3;
    localparam int LAST_SEEN_BIT = 7;

    localparam logic [LVL_W-1:0] CTRL_LVL_RST = 3'h0;
    localparam logic [DW-1:0]    FLAGS_RST    = 8'h00;
    localparam logic [DW-1:0]    LAST_RST     = 8'h00;
    localparam logic [SWI_W-1:0] SWI_SP_MAX   = 6'h1f;

    typedef logic [LVL_W-1:0] ciaf_lvl_t;

    // processor flag byte as software sees it
    typedef struct packed {
        logic      pad7;
        ciaf_lvl_t ppl;
        logic      pad3;
        logic      rsv;
        logic      stack_sel;
        logic      gie;
    } ciaf_flags_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ciaf_bus_t;

    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] num;
        ciaf_lvl_t        level;
    } ciaf_irq_t;
endpackage

// ---- core/ciaf_src_ctrl.sv ----
// one per-source interrupt control register
`timescale 1ns/10ps
module ciaf_src_ctrl (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   wr_en,
    input  wire logic [ciaf_pkg::DW-1:0] wdata,
    input  wire logic                   req_in,
    input  wire logic                   ack_clr,
    output      logic [ciaf_pkg::DW-1:0] ctrl
);
    import ciaf_pkg::*;

    logic [DW-1:0] ctrl_reg;
    logic [DW-1:0] ctrl_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_en) begin
            ctrl_next = wdata;
            // software may only withdraw a pending request
            ctrl_next[CTRL_REQ_BIT] = ctrl_reg[CTRL_REQ_BIT] & wdata[CTRL_REQ_BIT];
        end
        if (ack_clr) begin
            ctrl_next[CTRL_REQ_BIT] = 1'b0;
        end
        // a fresh request beats any clear in the same cycle
        if (req_in) begin
            ctrl_next[CTRL_REQ_BIT] = 1'b1;
        end
    end

    // upper bits are left alone by reset; level 0 keeps a stale request harmless
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_reg[LVL_W-1:0] <= CTRL_LVL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl = ctrl_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_ctrl_low_reset: assert property (
        $past(!rstn) |-> ctrl_reg[LVL_W-1:0] == CTRL_LVL_RST
    ) else $error("level bits not cleared by reset");

    a_req_set_wins: assert property (
        req_in |=> ctrl_reg[CTRL_REQ_BIT]
    ) else $error("request lost against a clear");

    c_req_vs_clear: cover property (req_in && (ack_clr || wr_en));
endmodule

// ---- core/ciaf_arbiter.sv ----
// picks the highest pending source above the processor priority level
`timescale 1ns/10ps
module ciaf_arbiter #(
    parameter int NUM_SRC = 8
) (
    input  wire logic                                gie,
    input  wire ciaf_pkg::ciaf_lvl_t                 ppl,
    input  wire logic [NUM_SRC-1:0]                  pend,
    input  wire ciaf_pkg::ciaf_lvl_t [NUM_SRC-1:0]   lvl,
    output      ciaf_pkg::ciaf_irq_t                 win
);
    import ciaf_pkg::*;

    if (NUM_SRC < 1 || NUM_SRC > (1 << VEC_W)) begin : g_bad_num
        $error("NUM_SRC does not fit the vector field");
    end

    always_comb begin
        win       = '0;
        win.level = ppl;
        for (int i = 0; i < NUM_SRC; i++) begin
            // strictly above: equal levels are held off, ties keep the lower source
            if (pend[i] && (lvl[i] > win.level)) begin
                win.valid = 1'b1;
                win.num   = VEC_W'(i);
                win.level = lvl[i];
            end
        end
        if (!gie) begin
            win = '0;
        end
    end
endmodule

// ---- testbench/ciaf_core_model.sv ----
// core-side model: takes an offered interrupt after a chosen delay
`timescale 1ns/10ps
module ciaf_core_model (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic                go,
    input  wire logic [1:0]          dly,
    input  wire ciaf_pkg::ciaf_irq_t irq,
    output      logic                ack
);
    import ciaf_pkg::*;

    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic       ack_reg;
    logic       ack_next;

    // ack only while an offer stands, and drops after one cycle so one offer is taken once
    always_comb begin
        cnt_next = '0;
        ack_next = 1'b0;
        if (go && irq.valid && !ack_reg) begin
            if (cnt_reg == dly) begin
                ack_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ack_reg <= ack_next;
        end
    end

    assign ack = ack_reg;
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the interrupt accept flag unit
`timescale 1ns/10ps
module tb_top;
    import ciaf_pkg::*;

    logic             mclk       = 1'b0;
    logic             rstn       = 1'b0;
    ciaf_bus_t        bus        = '0;
    logic [DW-1:0]    rdata;
    logic [7:0]       src_req    = '0;
    logic             ack;
    logic             swi_exec   = 1'b0;
    logic [SWI_W-1:0] swi_num    = '0;
    logic             flags_load = 1'b0;
    ciaf_flags_t      flags_val  = '0;
    ciaf_irq_t        irq;
    ciaf_flags_t      flags;
    logic             user_sp;
    logic             go         = 1'b0;
    logic [1:0]       dly        = '0;
    int               err_count  = 0;
    int               n_checks   = 0;
    int               s;
    logic [DW-1:0]    d;
    logic [2:0]       lv;
    logic [2:0]       pl;
    logic             g;

    always #25 mclk = ~mclk;

    ciaf_accept_flags dut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .src_req(src_req), .ack(ack),
        .swi_exec(swi_exec), .swi_num(swi_num), .flags_load(flags_load), .flags_val(flags_val), .irq(irq),
        .flags(flags), .user_sp(user_sp));
    ciaf_core_model core (.mclk(mclk), .rstn(rstn), .go(go), .dly(dly), .irq(irq), .ack(ack));

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // software keeps the reserved bit and both pads at zero
    function automatic logic [7:0] fbyte(input logic [2:0] p, input logic u, input logic e);
        return {1'b0, p, 2'b00, u, e};
    endfunction

    task automatic wait_ack();
        int k = 0;
        while (flags.gie !== 1'b0 && k < 20) begin
            @(posedge mclk);
            #1 k++;
        end
        if (flags.gie !== 1'b0) begin
            err_count++;
            results();
        end
    endtask

    initial begin
        void'($urandom(2));
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        #1 chk(flags, FLAGS_RST);
        chk({7'h00, user_sp}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(8'(OFF_SRC + i));
            chk({5'h00, d[2:0]}, 8'h00);
            // request bits leave reset unknown; clear them before any pending read
            wr(8'(OFF_SRC + i), 8'h00);
        end
        rd(8'h20);
        chk(d, 8'h00);
        for (int p = 0; p < 8; p++) begin
            wr(OFF_FLAGS, fbyte(3'(p), p[0], 1'b0));
            rd(OFF_FLAGS);
            chk(d, fbyte(3'(p), p[0], 1'b0));
            chk({7'h00, user_sp}, {7'h00, p[0]});
        end
        for (int t = 0; t < 40; t++) begin
            s = $urandom % 8;
            lv = 3'($urandom);
            pl = 3'($urandom);
            g = 1'($urandom);
            // equal level, one above, and a strong request while disabled
            if (t == 0) begin
                lv = 3'h4;
                pl = 3'h4;
                g = 1'b1;
            end
            if (t == 1) begin
                lv = 3'h5;
                pl = 3'h4;
                g = 1'b1;
            end
            if (t == 2) begin
                lv = 3'h7;
                pl = 3'h0;
                g = 1'b0;
            end
            dly <= 2'($urandom);
            wr(8'(OFF_SRC + s), {5'h00, lv});
            wr(OFF_FLAGS, fbyte(pl, 1'b1, g));
            @(posedge mclk) src_req[s] <= 1'b1;
            @(posedge mclk) src_req[s] <= 1'b0;
            repeat (2) @(posedge mclk);
            #1 chk({7'h00, irq.valid}, {7'h00, g && lv > pl});
            rd(OFF_PEND_LO);
            chk(d, 8'(1 << s));
            rd(OFF_PEND_HI);
            chk(d, 8'h00);
            if (g && lv > pl) begin
                chk({1'b0, irq.level, irq.num}, {1'b0, lv, 4'(s)});
                go <= 1'b1;
                wait_ack();
                go <= 1'b0;
                chk(flags, fbyte(lv, 1'b0, 1'b0));
                chk({7'h00, user_sp}, 8'h00);
                rd(OFF_LAST);
                chk(d, {1'b1, 3'h0, 4'(s)});
                rd(OFF_LAST);
                chk(d, {4'h0, 4'(s)});
                rd(OFF_PEND_LO);
                chk(d, 8'h00);
            end
            wr(8'(OFF_SRC + s), 8'h00);
        end
        for (int n = 0; n < 6; n++) begin
            wr(OFF_FLAGS, fbyte(3'h5, 1'b1, 1'b1));
            @(posedge mclk);
            swi_exec <= 1'b1;
            swi_num <= (n < 2) ? 6'(31 + n) : 6'($urandom);
            @(posedge mclk) swi_exec <= 1'b0;
            #1 chk(flags, fbyte(3'h5, swi_num > SWI_SP_MAX, 1'b0));
        end
        for (int n = 0; n < 4; n++) begin
            @(posedge mclk);
            flags_load <= 1'b1;
            flags_val <= ciaf_flags_t'(8'($urandom) & 8'h73);
            @(posedge mclk) flags_load <= 1'b0;
            #1 chk(flags, flags_val);
            chk({7'h00, user_sp}, {7'h00, flags_val.stack_sel});
        end
        // reset in mid-run with a non-zero level stored in one control register
        wr(8'(OFF_SRC + 3), 8'h05);
        @(posedge mclk) rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        #1 chk(flags, FLAGS_RST);
        rd(8'(OFF_SRC + 3));
        chk({5'h00, d[2:0]}, 8'h00);
        results();
    end
endmodule
